/* rtl/pcsan_pkg.sv */
package pcsan_pkg;
	localparam int unsigned CLK_HZ           = 10_000_000;
	localparam int unsigned UNIT_NS          = 32768;
	localparam int unsigned UNIT_CYC_DOC     = 4096;
	localparam int unsigned UNIT_CYC         = (UNIT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam logic [8:0]  LT_BASEX_DEF     = 9'h13d;
	localparam logic [8:0]  LT_SGMII_DEF     = 9'h032;
	localparam int unsigned CFG_LOOP_BIT     = 1;
	localparam int unsigned CFG_PDN_BIT      = 2;
	localparam int unsigned CFG_ISO_BIT      = 3;
	localparam logic [7:0]  A_CTRL           = 8'h00;
	localparam logic [7:0]  A_STAT           = 8'h04;
	localparam logic [7:0]  A_ADV            = 8'h08;
	localparam logic [7:0]  A_LPA            = 8'h0c;
	localparam logic [7:0]  A_IRQ            = 8'h10;
	localparam int unsigned CTRL_RESTART     = 9;
	localparam int unsigned CTRL_ANEN        = 12;
	localparam int unsigned STAT_DONE        = 5;
	localparam int unsigned IRQ_EN           = 0;
	localparam int unsigned IRQ_STAT         = 1;
	localparam logic [15:0] ADV_RST          = 16'h0020;
	localparam logic [15:0] CTRL_RST         = 16'h1000;
	typedef enum logic [1:0] {
		PCSAN_IDLE = 2'b00,
		PCSAN_TXA  = 2'b01,
		PCSAN_ACK  = 2'b10,
		PCSAN_DONE = 2'b11
	} pcsan_st_e;
	typedef struct packed {
		logic        loopback;
		logic        wrap;
		logic        powerdown;
		logic        isolate;
	} pcsan_ctl_s;
	typedef struct packed {
		logic        valid;
		logic [15:0] word;
	} pcsan_cw_s;
endpackage

/* rtl/pcsan_top.sv */
// Design decisions made here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
module pcsan_top
	import pcsan_pkg::*;
#(
	parameter bit          HAS_MGMT = 1'b1,
	parameter bit          USE_TBI  = 1'b0,
	parameter int unsigned UNIT     = UNIT_CYC
)(
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	input  wire logic [3:0]  configuration_vector,
	input  wire logic        sgmii_mode,
	input  wire logic [8:0]  link_timer_value,
	input  wire logic        sync_ok,
	input  wire pcsan_cw_s   rx_cw,
	output pcsan_cw_s        tx_cw,
	output pcsan_ctl_s       ctl,
	output logic             negotiation_done_irq,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp
);
	logic [3:0]  cfg_m_q;
	logic [3:0]  cfg_q;
	logic        sync_m_q;
	logic        sync_q;
	logic        sync_d1_q;
	logic        pdn_q;
	logic [15:0] ctrl_q;
	logic [15:0] adv_q;
	logic [15:0] lpa_q;
	logic        done_q;
	logic        irq_en_q;
	logic        irq_st_q;
	logic        restart_q;
	logic        partner_q;
	logic        wr_ph_q;
	logic [7:0]  wa_q;
	pcsan_st_e   st_q;
	logic [8:0]  lt_q;
	logic [8:0]  units_q;
	logic [31:0] div_q;
	logic [31:0] neg_cyc_q;
	logic [31:0] per_cyc_q;
	logic        sync_loss;
	logic        partner_start;
	logic        an_en;
	logic        start;
	logic        tick;
	logic        expire;
	logic        wr;
	logic        w_ctrl;
	logic        w_adv;
	logic        w_irq;
	// Two flops per bit; the pins may come from any clock
	always_ff @(posedge ref_clk or negedge reset_n)
		if (!reset_n)
		begin
			cfg_m_q  <= 4'h0;
			cfg_q    <= 4'h0;
			sync_m_q <= 1'b0;
			sync_q   <= 1'b0;
		end
		else
		begin
			cfg_m_q  <= configuration_vector;
			cfg_q    <= cfg_m_q;
			sync_m_q <= sync_ok;
			sync_q   <= sync_m_q;
		end
	// Bit 0 is never looked at
	always_ff @(posedge ref_clk or negedge reset_n)
		if (!reset_n)
			pdn_q <= 1'b0;
		else if (!HAS_MGMT && !USE_TBI && cfg_q[CFG_PDN_BIT])
			pdn_q <= 1'b1;
	assign ctl.loopback  = !HAS_MGMT && !USE_TBI && cfg_q[CFG_LOOP_BIT];
	assign ctl.wrap      = !HAS_MGMT && USE_TBI && cfg_q[CFG_LOOP_BIT];
	assign ctl.powerdown = pdn_q;
	assign ctl.isolate   = !HAS_MGMT && cfg_q[CFG_ISO_BIT];
	// AHB-Lite slave, zero wait states
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign wr     = wr_ph_q;
	assign w_ctrl = wr && wa_q == A_CTRL;
	assign w_adv  = wr && wa_q == A_ADV;
	assign w_irq  = wr && wa_q == A_IRQ;
	always_ff @(posedge ref_clk or negedge reset_n)
		if (!reset_n)
		begin
			wr_ph_q <= 1'b0;
			wa_q    <= 8'h00;
			hrdata  <= 32'h0000_0000;
		end
		else if (hready)
		begin
			wr_ph_q <= hsel && htrans[1] && hwrite;
			wa_q    <= haddr[7:0];
			if (hsel && htrans[1] && !hwrite)
				unique case (haddr[7:0])
					A_CTRL:  hrdata <= {16'h0000, ctrl_q};
					A_STAT:  hrdata <= {26'h0, done_q, 5'h00};
					A_ADV:   hrdata <= {16'h0000, adv_q};
					A_LPA:   hrdata <= {16'h0000, lpa_q};
					A_IRQ:   hrdata <= {30'h0, irq_st_q, irq_en_q};
					default: hrdata <= 32'h0000_0000;
				endcase
		end
	// Negotiation logic exists only with management present
	assign an_en = HAS_MGMT && ctrl_q[CTRL_ANEN];
	always_ff @(posedge ref_clk or negedge reset_n)
		if (!reset_n)
		begin
			ctrl_q    <= CTRL_RST;
			adv_q     <= ADV_RST;
			restart_q <= 1'b0;
		end
		else
		begin
			if (w_ctrl)
				ctrl_q <= hwdata[15:0] & ~(16'h1 << CTRL_RESTART);
			restart_q <= w_ctrl && hwdata[CTRL_RESTART];
			if (w_adv)
				adv_q <= hwdata[15:0];
		end
	assign sync_loss     = sync_d1_q && !sync_q;
	assign partner_start = rx_cw.valid && rx_cw.word == 16'h0000 && st_q != PCSAN_IDLE;
	assign start = an_en && (st_q == PCSAN_IDLE || sync_loss || partner_start || restart_q);
	assign tick   = div_q == UNIT - 1;
	assign expire = tick && units_q >= lt_q - 9'h1;
	always_ff @(posedge ref_clk or negedge reset_n)
		if (!reset_n)
		begin
			st_q      <= PCSAN_IDLE;
			lt_q      <= 9'h001;
			units_q   <= 9'h000;
			div_q     <= 32'h0;
			lpa_q     <= 16'h0000;
			done_q    <= 1'b0;
			sync_d1_q <= 1'b0;
			partner_q <= 1'b0;
		end
		else
		begin
			sync_d1_q <= sync_q;
			if (!an_en)
			begin
				st_q   <= PCSAN_IDLE;
				done_q <= 1'b0;
			end
			else if (start)
			begin
				st_q      <= PCSAN_TXA;
				lt_q      <= (link_timer_value == 9'h0) ? 9'h001 : link_timer_value;
				units_q   <= 9'h000;
				div_q     <= 32'h0;
				done_q    <= 1'b0;
				partner_q <= 1'b0;
			end
			else
			begin
				div_q <= tick ? 32'h0 : div_q + 32'h1;
				if (tick)
					units_q <= expire ? 9'h000 : units_q + 9'h1;
				if (st_q == PCSAN_TXA && rx_cw.valid && rx_cw.word != 16'h0000)
				begin
					lpa_q     <= rx_cw.word;
					partner_q <= 1'b1;
				end
				if (expire)
					unique case (st_q)
						PCSAN_IDLE: st_q <= PCSAN_IDLE;
						PCSAN_TXA:  st_q <= partner_q ? PCSAN_ACK : PCSAN_TXA;
						PCSAN_ACK:  st_q <= PCSAN_DONE;
						PCSAN_DONE: st_q <= PCSAN_DONE;
					endcase
				if (expire && st_q == PCSAN_ACK)
					done_q <= 1'b1;
			end
		end
	assign tx_cw.valid = st_q == PCSAN_TXA || st_q == PCSAN_ACK;
	assign tx_cw.word  = adv_q | ((st_q == PCSAN_ACK) ? 16'h4000 : 16'h0000);
	wire done_rise = expire && st_q == PCSAN_ACK && an_en && !start;
	always_ff @(posedge ref_clk or negedge reset_n)
		if (!reset_n)
		begin
			irq_en_q <= 1'b0;
			irq_st_q <= 1'b0;
		end
		else
		begin
			if (w_irq)
				irq_en_q <= hwdata[IRQ_EN];
			if (done_rise && irq_en_q)
				irq_st_q <= 1'b1;
			else if ((w_irq && !hwdata[IRQ_STAT]) || (w_irq && !hwdata[IRQ_EN]))
				irq_st_q <= 1'b0;
		end
	assign negotiation_done_irq = irq_en_q && irq_st_q;
	// Cycle counters exist only to bound the timer in the checks below
	always_ff @(posedge ref_clk or negedge reset_n)
		if (!reset_n)
		begin
			neg_cyc_q <= 32'h0;
			per_cyc_q <= 32'h0;
		end
		else if (start || !an_en)
		begin
			neg_cyc_q <= 32'h0;
			per_cyc_q <= 32'h0;
		end
		else
		begin
			neg_cyc_q <= neg_cyc_q + 32'h1;
			per_cyc_q <= expire ? 32'h0 : per_cyc_q + 32'h1;
		end
	irq_sticky_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		irq_st_q && !w_irq |=> irq_st_q)
		else $error("irq lost");
	irq_set_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		done_rise && irq_en_q |=> negotiation_done_irq)
		else $error("irq not set");
	irq_off_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!irq_en_q |-> !negotiation_done_irq)
		else $error("irq while disabled");
	done_off_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!an_en |=> !done_q)
		else $error("done while disabled");
	tx_quiet_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!an_en |=> !tx_cw.valid)
		else $error("sending while disabled");
	tx_adv_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		st_q == PCSAN_TXA |-> tx_cw.word == adv_q)
		else $error("adv not sent");
	ack_bit_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		st_q == PCSAN_ACK |-> tx_cw.valid && tx_cw.word[14])
		else $error("ack word wrong");
	adv_wr_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		w_adv |=> adv_q == $past(hwdata[15:0]))
		else $error("adv write lost");
	stat_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		hready && hsel && htrans[1] && !hwrite && haddr[7:0] == A_STAT
		|=> hrdata[STAT_DONE] == $past(done_q))
		else $error("status read wrong");
	pdn_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		pdn_q |=> pdn_q)
		else $error("powerdown cleared");
	pdn_set_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!HAS_MGMT && !USE_TBI && cfg_q[CFG_PDN_BIT] |=> ctl.powerdown)
		else $error("powerdown not set");
	pdn_tbi_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		USE_TBI |-> !ctl.powerdown)
		else $error("powerdown in tbi build");
	iso_sync_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!HAS_MGMT |-> ctl.isolate == $past(configuration_vector[CFG_ISO_BIT], 2))
		else $error("isolate");
	loop_cfg_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!HAS_MGMT && !USE_TBI |-> ctl.loopback == $past(configuration_vector[CFG_LOOP_BIT], 2))
		else $error("loopback");
	wrap_cfg_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!HAS_MGMT && USE_TBI |-> ctl.wrap == $past(configuration_vector[CFG_LOOP_BIT], 2))
		else $error("wrap");
	mgmt_quiet_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		HAS_MGMT |-> ctl == 4'h0)
		else $error("controls with management");
	restart_go_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		restart_q && an_en |=> st_q == PCSAN_TXA && units_q == 9'h0)
		else $error("restart");
	restart_clr_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!ctrl_q[CTRL_RESTART])
		else $error("restart bit stuck");
	sync_rst_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		sync_loss && an_en |=> st_q == PCSAN_TXA && !done_q)
		else $error("sync loss ignored");
	partner_rst_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		partner_start && an_en |=> st_q == PCSAN_TXA)
		else $error("partner restart ignored");
	lt_load_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		start && link_timer_value != 9'h0 |=> lt_q == $past(link_timer_value))
		else $error("timer value not sampled");
	timer_lim_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		units_q < lt_q)
		else $error("timer overrun");
	per_len_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		expire && an_en && !start |-> per_cyc_q + 32'h1 <= lt_q * UNIT
		&& per_cyc_q + 32'h1 > (lt_q - 9'h1) * UNIT)
		else $error("timer period");
	neg_len_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		done_rise |-> neg_cyc_q + 32'h1 >= 2 * lt_q * UNIT)
		else $error("negotiation too short");
	lpa_cap_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		st_q == PCSAN_TXA && rx_cw.valid && rx_cw.word != 16'h0 && an_en && !start
		|=> lpa_q == $past(rx_cw.word))
		else $error("lpa");
	done_c: cover property (@(posedge ref_clk) done_rise);
	irq_c: cover property (@(posedge ref_clk) negotiation_done_irq);
	restart_c: cover property (@(posedge ref_clk) restart_q && st_q == PCSAN_DONE);
	sync_c: cover property (@(posedge ref_clk) sync_loss && an_en);
	pdn_c: cover property (@(posedge ref_clk) ctl.powerdown);
endmodule // pcsan_top

/* tb/pcsan_partner.sv */
`timescale 1ns/1ns
module pcsan_partner
	import pcsan_pkg::*;
#(
	parameter logic [15:0] ABILITY = 16'h01a0
)(
	input  wire logic      ref_clk,
	input  wire logic      reset_n,
	input  wire pcsan_cw_s tx_cw,
	output pcsan_cw_s      rx_cw
);
	logic [2:0] cnt_q;
	logic       seen_q;
	wire        send = tx_cw.valid && (cnt_q == 3'h0);
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cnt_q  <= 3'h0;
			seen_q <= 1'b0;
			rx_cw  <= '0;
		end
		else
		begin
			cnt_q       <= cnt_q + 3'h1;
			seen_q      <= seen_q | tx_cw.valid;
			// Speaks only while the device negotiates too
			rx_cw.valid <= send;
			// Idle word toggles so a stale value is never mistaken for data
			rx_cw.word  <= send ? (ABILITY | {1'b0, seen_q, 14'h0}) : ~rx_cw.word;
		end
	end
endmodule // pcsan_partner

/* tb/pcsan_top_bench.sv */
`timescale 1ns/1ns
module pcsan_top_bench
	import pcsan_pkg::*;
;
	localparam logic [8:0] LT = 9'h003;
	localparam int         UN = 4;
	logic        ref_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [3:0]  cv      = 4'h0;
	logic        sync_ok = 1'b1;
	logic        hsel    = 1'b0;
	logic        hwrite  = 1'b0;
	logic [1:0]  htrans  = 2'h0;
	logic [31:0] haddr   = 32'h0;
	logic [31:0] hwdata  = 32'h0;
	logic [31:0] hrdata;
	logic [31:0] d;
	logic        hreadyout;
	logic        irq;
	wire         hready  = hreadyout;
	pcsan_cw_s   rx_cw;
	pcsan_cw_s   tx_cw;
	pcsan_ctl_s  ctl2;
	pcsan_ctl_s  ctl3;
	pcsan_ctl_s  ctl_m;
	pcsan_cw_s   rx_cw_sg;
	pcsan_cw_s   tx_cw_sg;
	pcsan_cw_s   rx_cw_bx;
	pcsan_cw_s   tx_cw_bx;
	logic        hresp;
	logic        irq_cfg;
	logic        irq_sg;
	logic        irq_bx;
	int          n_mismatch = 0;
	int          n_checks = 0;
	always #50 ref_clk = ~ref_clk;
	pcsan_top #(.UNIT(UN)) i_pcsan_top (.ref_clk(ref_clk), .reset_n(reset_n),
		.configuration_vector(cv), .sgmii_mode(1'b0), .link_timer_value(LT),
		.sync_ok(sync_ok), .rx_cw(rx_cw), .tx_cw(tx_cw), .ctl(ctl_m),
		.negotiation_done_irq(irq), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
	// Second build without management, only its control outputs and its interrupt matter
	pcsan_top #(.HAS_MGMT(1'b0), .UNIT(UN)) i_pcsan_top_cfg (.ref_clk(ref_clk),
		.reset_n(reset_n), .configuration_vector(cv), .sgmii_mode(1'b0),
		.link_timer_value(LT), .sync_ok(sync_ok), .rx_cw(rx_cw), .tx_cw(),
		.ctl(ctl2), .negotiation_done_irq(irq_cfg), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hready), .hrdata(), .hreadyout(), .hresp());
	pcsan_partner i_pcsan_partner (.ref_clk(ref_clk), .reset_n(reset_n),
		.tx_cw(tx_cw), .rx_cw(rx_cw));
	pcsan_top #(.HAS_MGMT(1'b0), .USE_TBI(1'b1), .UNIT(UN)) i_pcsan_top_tbi (.ref_clk(ref_clk),
		.reset_n(reset_n), .configuration_vector(cv), .sgmii_mode(1'b0),
		.link_timer_value(LT), .sync_ok(sync_ok), .rx_cw(rx_cw), .tx_cw(),
		.ctl(ctl3), .negotiation_done_irq(), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hready), .hrdata(), .hreadyout(), .hresp());
	// Suggested timer values, each with its own partner
	pcsan_top #(.UNIT(UN)) i_pcsan_top_sg (.ref_clk(ref_clk), .reset_n(reset_n),
		.configuration_vector(cv), .sgmii_mode(1'b1), .link_timer_value(LT_SGMII_DEF),
		.sync_ok(sync_ok), .rx_cw(rx_cw_sg), .tx_cw(tx_cw_sg), .ctl(),
		.negotiation_done_irq(irq_sg), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hrdata(), .hreadyout(), .hresp());
	pcsan_partner i_pcsan_partner_sg (.ref_clk(ref_clk), .reset_n(reset_n),
		.tx_cw(tx_cw_sg), .rx_cw(rx_cw_sg));
	pcsan_top #(.UNIT(UN)) i_pcsan_top_bx (.ref_clk(ref_clk), .reset_n(reset_n),
		.configuration_vector(cv), .sgmii_mode(1'b0), .link_timer_value(LT_BASEX_DEF),
		.sync_ok(sync_ok), .rx_cw(rx_cw_bx), .tx_cw(tx_cw_bx), .ctl(),
		.negotiation_done_irq(irq_bx), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hrdata(), .hreadyout(), .hresp());
	pcsan_partner i_pcsan_partner_bx (.ref_clk(ref_clk), .reset_n(reset_n),
		.tx_cw(tx_cw_bx), .rx_cw(rx_cw_bx));
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("BAD %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge ref_clk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= {24'h0, a};
		hwrite <= w;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		d = hrdata;
		chk(hresp, 1'b0);
	endtask
	task wait_done();
		for (int i = 0; i < 100; i++)
		begin
			bus(1'b0, A_STAT, 32'h0);
			if (d[STAT_DONE] === 1'b1)
				break;
		end
	endtask
	task t_regs();
		bus(1'b0, A_CTRL, 32'h0);
		chk(d, {16'h0, CTRL_RST});
		bus(1'b0, A_ADV, 32'h0);
		chk(d, {16'h0, ADV_RST});
		bus(1'b1, 8'h20, 32'hffff);
		bus(1'b0, 8'h20, 32'h0);
		chk(d, 32'h0);
	endtask
	task t_first();
		wait_done();
		chk(d[STAT_DONE], 1'b1);
		chk(irq, 1'b0);
		bus(1'b0, A_LPA, 32'h0);
		chk(d[13:0], 14'h01a0);
	endtask
	task t_restart();
		int  n;
		logic seen;
		n    = 0;
		seen = 1'b0;
		bus(1'b1, A_ADV, 32'h0180);
		bus(1'b1, A_IRQ, 32'h1);
		bus(1'b1, A_CTRL, 32'h1200);
		bus(1'b0, A_STAT, 32'h0);
		chk(d[STAT_DONE], 1'b0);
		while (irq !== 1'b1 && n < 500)
		begin
			@(posedge ref_clk);
			n++;
			if (tx_cw.valid === 1'b1 && (tx_cw.word & 16'hbfff) === 16'h0180)
				seen = 1'b1;
		end
		chk(seen, 1'b1);
		chk(n + 5 >= 2 * (LT - 1) * UN, 1'b1);
		chk(irq, 1'b1);
		bus(1'b0, A_STAT, 32'h0);
		chk(d[STAT_DONE], 1'b1);
		bus(1'b1, A_IRQ, 32'h1);
		@(posedge ref_clk);
		chk(irq, 1'b0);
	endtask
	task t_sync();
		@(posedge ref_clk);
		sync_ok <= 1'b0;
		repeat (4) @(posedge ref_clk);
		sync_ok <= 1'b1;
		bus(1'b0, A_STAT, 32'h0);
		chk(d[STAT_DONE], 1'b0);
		wait_done();
		chk(d[STAT_DONE], 1'b1);
	endtask
	task t_cfg(input logic [3:0] v, input logic [3:0] e);
		@(posedge ref_clk);
		cv <= v;
		// Two sync flops plus margin
		repeat (4) @(posedge ref_clk);
		chk(ctl2, e);
		chk(ctl3, {1'b0, e[3], 1'b0, e[0]});
		chk(ctl_m, 4'h0);
		chk(irq_cfg, 1'b0);
	endtask
	task t_timers();
		int n;
		n = 0;
		bus(1'b1, A_IRQ, 32'h1);
		bus(1'b1, A_CTRL, 32'h1200);
		while (irq_sg !== 1'b1 && n < 1000)
		begin
			@(posedge ref_clk);
			n++;
		end
		chk(n >= 2 * (LT_SGMII_DEF - 1) * UN && n <= 2 * LT_SGMII_DEF * UN + 3, 1'b1);
		while (irq_bx !== 1'b1 && n < 3000)
		begin
			@(posedge ref_clk);
			n++;
		end
		chk(n >= 2 * (LT_BASEX_DEF - 1) * UN && n <= 2 * LT_BASEX_DEF * UN + 3, 1'b1);
	endtask
	task final_report();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		repeat (8) @(posedge ref_clk);
		reset_n <= 1'b1;
		t_regs();
		t_first();
		t_restart();
		t_sync();
		t_cfg(4'b0001, 4'b0000);
		t_cfg(4'b1010, 4'b1001);
		t_cfg(4'b0100, 4'b0010);
		t_cfg(4'b0000, 4'b0010);
		t_timers();
		final_report();
	end
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		n_mismatch++;
		final_report();
	end
endmodule // pcsan_top_bench
